// ===== verilog/sdpm_monitor.sv
`timescale 1ns/1ps
// Function
// - Thermal resistance reaching warning level lights over-temperature display, drive stays enabled.
// - Thermal resistance reaching trip level disables the drive output stage.
// - Two overcurrent modes: fusing disables the drive, limiting only clamps current.
// - Fusing: blink at warning level; still above after one second gives fault.
// - Both modes clamp output current to rated value once estimate reaches it.
// - Limiting: blink while estimate above warning level, no disable.
// - From zero at max current, blink starts after 3.3 s times ratio squared.
// - From zero at max current, clamp starts after 4 s times ratio squared.
// - Max current equal to rated current never raises the overcurrent fault.
// - Limit threshold percent is rated percent squared over 50.
// - Pulses between successive markers must equal resolution times marker pitch; pitch 15 requires every marker at the first marker's position.
// - Pulse rate reaching 1.5 times maximum encoder frequency is a counting fault.
// - A counting fault disables the drive at once.
// - Absolute mode faults when position error exceeds following threshold.
// - Relative mode faults when error minus model error exceeds threshold.
// - Displayed speed is pole pairs times mechanical speed.
// - Marker pitch 0 disables the marker check, keeping the frequency check.
// - Any fault disables; all but undervoltage open relay, undervoltage if configured.
module sdpm_monitor #(
  parameter int CTRL_PERIOD = sdpm_pkg::CTRL_PERIOD_CYC,
  parameter int FREQ_WIN    = sdpm_pkg::FREQ_WIN_CYC
) (
  input  wire logic               i_clock,
  input  wire logic               i_rst_n,
  input  wire logic [7:0]         i_addr,
  input  wire logic [31:0]        i_wdata,
  input  wire logic               i_wr,
  input  wire logic               i_rd,
  output logic [31:0]             o_rdata,
  input  wire logic [15:0]        i_therm_res,
  input  wire logic [7:0]         i_current_pct,
  input  wire logic               i_enc_step,
  input  wire logic               i_enc_dir,
  input  wire logic               i_enc_marker,
  input  wire logic signed [31:0] i_pos_err,
  input  wire logic signed [31:0] i_model_err,
  input  wire logic [15:0]        i_mech_speed,
  input  wire logic               i_undervolt,
  input  wire logic               i_fault_reset,
  output logic                    o_drive_enable,
  output logic                    o_drive_healthy_relay,
  output logic [7:0]              o_current_limit_pct,
  output logic [19:0]             o_disp_speed,
  output sdpm_pkg::sdpm_fault_t   o_faults,
  output sdpm_pkg::sdpm_ind_t     o_ind
);
  import sdpm_pkg::*;

  function automatic logic [31:0] abs32(input logic signed [31:0] v);
    abs32 = v[31] ? 32'(-v) : 32'(v);
  endfunction : abs32

  function automatic logic [15:0] sq8(input logic [7:0] v);
    sq8 = 16'(v) * 16'(v);
  endfunction : sq8

  logic [4:0]  ctrl_q;
  logic [15:0] therm_warn_q;
  logic [15:0] therm_trip_q;
  logic [7:0]  rated_q;
  logic [7:0]  max_cur_q;
  logic [15:0] cpr_q;
  logic [3:0]  pitch_q;
  logic [15:0] max_speed_q;
  logic [31:0] follow_thr_q;
  logic [3:0]  pole_pairs_q;
  sdpm_fault_t fault_q;
  sdpm_fault_t fault_set;
  logic        clear;

  // Register writes
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      ctrl_q       <= CTRL_RST;
      therm_warn_q <= THERM_WARN_RST;
      therm_trip_q <= THERM_TRIP_RST;
      rated_q      <= RATED_CUR_RST;
      max_cur_q    <= MAX_CUR_RST;
      cpr_q        <= ENC_CPR_RST;
      pitch_q      <= MARK_PITCH_RST;
      max_speed_q  <= MAX_SPEED_RST;
      follow_thr_q <= FOLLOW_THR_RST;
      pole_pairs_q <= POLE_PAIRS_RST;
    end
    else
    begin
      ctrl_q[CTRL_CLEAR] <= 1'b0;
      if (i_wr)
      begin
        unique case (i_addr)
          ADDR_CTRL:       ctrl_q       <= i_wdata[4:0];
          ADDR_THERM_WARN: therm_warn_q <= i_wdata[15:0];
          ADDR_THERM_TRIP: therm_trip_q <= i_wdata[15:0];
          ADDR_RATED_CUR:  rated_q      <= i_wdata[7:0];
          ADDR_MAX_CUR:    max_cur_q    <= i_wdata[7:0];
          ADDR_ENC_CPR:    cpr_q        <= i_wdata[15:0];
          ADDR_MARK_PITCH: pitch_q      <= i_wdata[3:0];
          ADDR_MAX_SPEED:  max_speed_q  <= i_wdata[15:0];
          ADDR_FOLLOW_THR: follow_thr_q <= i_wdata;
          ADDR_POLE_PAIRS: pole_pairs_q <= i_wdata[3:0];
          default:         ;
        endcase
      end
    end
  end

  assign clear = i_fault_reset | ctrl_q[CTRL_CLEAR];

  // Control period tick
  logic [31:0] per_cnt_q;
  logic        tick;
  assign tick = (per_cnt_q == 32'(CTRL_PERIOD - 1));

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
      per_cnt_q <= 32'h0;
    else if (tick)
      per_cnt_q <= 32'h0;
    else
      per_cnt_q <= per_cnt_q + 32'h1;
  end

  // Thermal comparison
  logic therm_warn;
  logic therm_trip;
  always_comb
  begin
    if (ctrl_q[CTRL_PTC])
    begin
      therm_warn = i_therm_res >= therm_warn_q;
      therm_trip = i_therm_res >= therm_trip_q;
    end
    else
    begin
      therm_warn = i_therm_res <= therm_warn_q;
      therm_trip = i_therm_res <= therm_trip_q;
    end
  end

  logic therm_warn_q2;
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
      therm_warn_q2 <= 1'b0;
    else if (tick)
      therm_warn_q2 <= therm_warn;
  end

  // I2t integrator, first order with 4 s time constant
  logic [27:0] i2t_acc_q;
  logic [15:0] i2t_level;
  logic [15:0] rated_sq;
  logic        i2t_clamp;
  logic        i2t_warn;
  assign i2t_level = i2t_acc_q[27:12];
  assign rated_sq  = sq8(rated_q);
  assign i2t_clamp = i2t_level >= rated_sq;
  assign i2t_warn  = (24'(i2t_level) * 24'(WARN_DEN)) >= (24'(rated_sq) * 24'(WARN_NUM));

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
      i2t_acc_q <= 28'h0;
    else if (tick)
      i2t_acc_q <= i2t_acc_q + 28'(sq8(i_current_pct)) - 28'(i2t_acc_q >> I2T_SHIFT);
  end

  logic [10:0] fuse_cnt_q;
  logic        clamp_q;
  logic        blink_q;
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      fuse_cnt_q <= 11'h0;
      clamp_q    <= 1'b0;
      blink_q    <= 1'b0;
    end
    else if (tick)
    begin
      clamp_q <= i2t_clamp;
      blink_q <= i2t_warn;
      if (!i2t_warn || ctrl_q[CTRL_OC_LIMIT])
        fuse_cnt_q <= 11'h0;
      else if (fuse_cnt_q != 11'(FUSE_PERIODS))
        fuse_cnt_q <= fuse_cnt_q + 11'h1;
      if (!i2t_warn)
        blink_q <= 1'b0;
    end
  end

  logic [7:0] blink_div_q;
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
      blink_div_q <= 8'h0;
    else if (tick)
      blink_div_q <= blink_div_q + 8'h1;
  end

  // Encoder position and marker check
  logic signed [31:0] enc_pos_q;
  logic signed [31:0] mark_pos_q;
  logic               mark_seen_q;
  logic [31:0]        expect_cnt;
  logic               mark_bad;
  logic signed [31:0] pos_next;
  assign pos_next   = i_enc_step ? (i_enc_dir ? enc_pos_q - 32'sh1 : enc_pos_q + 32'sh1)
                                 : enc_pos_q;
  assign expect_cnt = 32'(cpr_q) * 32'(pitch_q);
  always_comb
  begin
    if (pitch_q == PITCH_SINGLE)
      mark_bad = pos_next != mark_pos_q;
    else
      mark_bad = abs32(pos_next - mark_pos_q) != expect_cnt;
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      enc_pos_q   <= 32'sh0;
      mark_pos_q  <= 32'sh0;
      mark_seen_q <= 1'b0;
    end
    else
    begin
      enc_pos_q <= pos_next;
      if (clear || pitch_q == 4'h0)
        mark_seen_q <= 1'b0;
      else if (i_enc_marker)
      begin
        mark_seen_q <= 1'b1;
        if (pitch_q != PITCH_SINGLE || !mark_seen_q)
          mark_pos_q <= pos_next;
      end
    end
  end

  // Pulse frequency ceiling: window 40 ms gives limit cpr*rpm/1000
  logic [31:0] win_cnt_q;
  logic [31:0] win_pulses_q;
  logic [31:0] freq_limit;
  assign freq_limit = (32'(cpr_q) * 32'(max_speed_q)) / 32'd1000;

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      win_cnt_q    <= 32'h0;
      win_pulses_q <= 32'h0;
    end
    else if (win_cnt_q == 32'(FREQ_WIN - 1))
    begin
      win_cnt_q    <= 32'h0;
      win_pulses_q <= 32'(i_enc_step);
    end
    else
    begin
      win_cnt_q    <= win_cnt_q + 32'h1;
      win_pulses_q <= win_pulses_q + 32'(i_enc_step);
    end
  end

  // Following error
  logic follow_bad;
  always_comb
  begin
    if (ctrl_q[CTRL_FOLLOW_REL])
      follow_bad = abs32(i_pos_err - i_model_err) > follow_thr_q;
    else
      follow_bad = abs32(i_pos_err) > follow_thr_q;
  end

  // Fault sources
  always_comb
  begin
    fault_set.therm  = tick & therm_trip;
    fault_set.i2t    = tick & i2t_warn & ~ctrl_q[CTRL_OC_LIMIT]
                     & (fuse_cnt_q == 11'(FUSE_PERIODS))
                     & (max_cur_q > rated_q);
    fault_set.count  = (i_enc_marker & mark_seen_q & (pitch_q != 4'h0) & mark_bad)
                     | (win_pulses_q >= freq_limit);
    fault_set.follow = tick & follow_bad;
    fault_set.uv     = i_undervolt;
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
      fault_q <= '0;
    else
      fault_q <= fault_set | (clear ? '0 : fault_q);
  end

  // Speed display
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
      o_disp_speed <= 20'h0;
    else
      o_disp_speed <= 20'(i_mech_speed) * 20'(pole_pairs_q);
  end

  // Outputs
  assign o_faults              = fault_q;
  assign o_drive_enable        = fault_q == '0;
  assign o_drive_healthy_relay = ({fault_q.follow, fault_q.count, fault_q.i2t, fault_q.therm}
                                  == 4'h0) & ~(fault_q.uv & ctrl_q[CTRL_UV_RELAY]);
  assign o_current_limit_pct   = clamp_q ? rated_q : max_cur_q;
  assign o_ind.therm_warn      = therm_warn_q2;
  assign o_ind.oc_blink        = blink_q & blink_div_q[BLINK_BIT - 1];
  assign o_ind.oc_clamp        = clamp_q;

  // Register read, data one cycle later
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
      o_rdata <= 32'h0;
    else if (i_rd)
    begin
      unique case (i_addr)
        ADDR_CTRL:       o_rdata <= 32'(ctrl_q);
        ADDR_THERM_WARN: o_rdata <= 32'(therm_warn_q);
        ADDR_THERM_TRIP: o_rdata <= 32'(therm_trip_q);
        ADDR_RATED_CUR:  o_rdata <= 32'(rated_q);
        ADDR_MAX_CUR:    o_rdata <= 32'(max_cur_q);
        ADDR_ENC_CPR:    o_rdata <= 32'(cpr_q);
        ADDR_MARK_PITCH: o_rdata <= 32'(pitch_q);
        ADDR_MAX_SPEED:  o_rdata <= 32'(max_speed_q);
        ADDR_FOLLOW_THR: o_rdata <= follow_thr_q;
        ADDR_POLE_PAIRS: o_rdata <= 32'(pole_pairs_q);
        ADDR_STATUS:     o_rdata <= {24'h0, o_ind, fault_q};
        ADDR_I2T_LEVEL:  o_rdata <= 32'(i2t_level / 16'd50);
        ADDR_DISP_SPEED: o_rdata <= 32'(o_disp_speed);
        default:         o_rdata <= 32'h0;
      endcase
    end
    else
      o_rdata <= 32'h0;
  end

endmodule : sdpm_monitor

// ===== inc/sdpm_pkg.sv
package sdpm_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL       = 8'h00;
  localparam logic [7:0] ADDR_THERM_WARN = 8'h04;
  localparam logic [7:0] ADDR_THERM_TRIP = 8'h08;
  localparam logic [7:0] ADDR_RATED_CUR  = 8'h0c;
  localparam logic [7:0] ADDR_MAX_CUR    = 8'h10;
  localparam logic [7:0] ADDR_ENC_CPR    = 8'h14;
  localparam logic [7:0] ADDR_MARK_PITCH = 8'h18;
  localparam logic [7:0] ADDR_MAX_SPEED  = 8'h1c;
  localparam logic [7:0] ADDR_FOLLOW_THR = 8'h20;
  localparam logic [7:0] ADDR_POLE_PAIRS = 8'h24;
  localparam logic [7:0] ADDR_STATUS     = 8'h28;
  localparam logic [7:0] ADDR_I2T_LEVEL  = 8'h2c;
  localparam logic [7:0] ADDR_DISP_SPEED = 8'h30;

  // Control register fields
  localparam int CTRL_OC_LIMIT  = 0;
  localparam int CTRL_FOLLOW_REL = 1;
  localparam int CTRL_UV_RELAY  = 2;
  localparam int CTRL_CLEAR     = 3;
  localparam int CTRL_PTC       = 4;

  // Reset values
  localparam logic [4:0]  CTRL_RST       = 5'h00;
  localparam logic [15:0] THERM_WARN_RST = 16'h0ce4;
  localparam logic [15:0] THERM_TRIP_RST = 16'h0ce4;
  localparam logic [7:0]  RATED_CUR_RST  = 8'h32;
  localparam logic [7:0]  MAX_CUR_RST    = 8'h64;
  localparam logic [15:0] ENC_CPR_RST    = 16'h0400;
  localparam logic [3:0]  MARK_PITCH_RST = 4'h1;
  localparam logic [15:0] MAX_SPEED_RST  = 16'h0bb8;
  localparam logic [31:0] FOLLOW_THR_RST = 32'h0000_1000;
  localparam logic [3:0]  POLE_PAIRS_RST = 4'h1;
  localparam logic [3:0]  PITCH_SINGLE   = 4'hf;

  // Timing
  localparam longint CLK_HZ         = 40000000;
  localparam int     I2T_TAU_S      = 4;
  localparam int     I2T_SHIFT      = 12;
  localparam int     CTRL_PERIOD_CYC = int'((I2T_TAU_S * CLK_HZ) >> I2T_SHIFT);
  localparam int     FUSE_TIME_MS   = 1000;
  localparam int     FUSE_PERIODS   = int'((longint'(FUSE_TIME_MS) * CLK_HZ)
                                           / (1000 * longint'(CTRL_PERIOD_CYC)));
  localparam int     FREQ_WIN_MS    = 40;
  localparam int     FREQ_WIN_CYC   = int'((longint'(FREQ_WIN_MS) * CLK_HZ) / 1000);
  localparam int     BLINK_BIT      = 7;
  // Warning level is 3.3/4 of the clamp level
  localparam logic [7:0] WARN_NUM   = 8'h21;
  localparam logic [7:0] WARN_DEN   = 8'h28;

  typedef struct packed {
    logic uv;
    logic follow;
    logic count;
    logic i2t;
    logic therm;
  } sdpm_fault_t;

  typedef struct packed {
    logic therm_warn;
    logic oc_blink;
    logic oc_clamp;
  } sdpm_ind_t;

endpackage : sdpm_pkg

// ===== sim/sdpm_monitor_sva.sv
`timescale 1ns/1ps
module sdpm_monitor_chk (
  input wire logic                  i_clock,
  input wire logic                  i_rst_n,
  input wire logic [7:0]            i_addr,
  input wire logic [31:0]           i_wdata,
  input wire logic                  i_wr,
  input wire logic                  i_rd,
  input wire logic [31:0]           o_rdata,
  input wire logic                  i_enc_step,
  input wire logic                  i_enc_marker,
  input wire logic                  i_undervolt,
  input wire logic                  i_fault_reset,
  input wire logic                  o_drive_enable,
  input wire logic                  o_drive_healthy_relay,
  input wire sdpm_pkg::sdpm_fault_t o_faults
);
  import sdpm_pkg::*;
  logic clr;
  logic clr_wr_q;
  // Clear bit acts one cycle after its write
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
      clr_wr_q <= 1'b0;
    else
      clr_wr_q <= i_wr & (i_addr == ADDR_CTRL) & i_wdata[CTRL_CLEAR];
  end
  assign clr = i_fault_reset | clr_wr_q;
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);
  a_enable_no_fault: assert property (o_drive_enable == (o_faults == 5'h00))
    else $error("enable disagrees with faults");
  a_relay_opens: assert property ((|o_faults[3:0]) |-> !o_drive_healthy_relay)
    else $error("relay closed with fault");
  a_relay_closed: assert property ((o_faults == 5'h00) |-> o_drive_healthy_relay)
    else $error("relay open without fault");
  a_uv_latches: assert property (i_undervolt |=> o_faults.uv && !o_drive_enable)
    else $error("undervoltage not latched");
  a_faults_held: assert property (!clr |=> (o_faults & $past(o_faults)) == $past(o_faults))
    else $error("fault dropped without clear");
  a_enable_clear_cause: assert property ($rose(o_drive_enable) |-> $past(clr))
    else $error("enable returned without clear");
  a_count_cause: assert property ($rose(o_faults.count) |->
    $past(i_enc_step | i_enc_marker) || $past(i_enc_step | i_wr, 2))
    else $error("count fault without encoder event");
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0000_0000)
    else $error("read data outside read slot");
endmodule : sdpm_monitor_chk

bind sdpm_monitor sdpm_monitor_chk u_chk (.i_clock, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd,
  .o_rdata, .i_enc_step, .i_enc_marker, .i_undervolt, .i_fault_reset, .o_drive_enable,
  .o_drive_healthy_relay, .o_faults);

// ===== sim/sdpm_motor_model.sv
`timescale 1ns/1ps
module sdpm_motor_model (
  input  wire logic       i_clock,
  input  wire logic       i_drive_enable,
  input  wire logic [7:0] i_limit_pct,
  input  wire logic [7:0] i_demand_pct,
  input  wire logic [7:0] i_gap,
  input  wire logic [7:0] i_per_mark,
  output logic            o_enc_step,
  output logic            o_enc_marker,
  output logic [7:0]      o_current_pct
);
  logic [7:0] cnt_q = 8'h00;
  logic [7:0] steps_q = 8'h00;
  initial o_enc_step = 1'b0;
  initial o_enc_marker = 1'b0;
  // Encoder: one step every i_gap cycles, marker every i_per_mark steps
  always @(posedge i_clock)
  begin
    o_enc_step <= 1'b0;
    o_enc_marker <= 1'b0;
    if (i_gap != 8'h00)
    begin
      cnt_q <= (cnt_q >= i_gap - 8'h01) ? 8'h00 : cnt_q + 8'h01;
      if (cnt_q == 8'h00)
      begin
        o_enc_step <= 1'b1;
        o_enc_marker <= (steps_q + 8'h01 == i_per_mark);
        steps_q <= (steps_q + 8'h01 == i_per_mark) ? 8'h00 : steps_q + 8'h01;
      end
    end
  end
  // Power stage: clamps demand to the limit, no current when disabled
  assign o_current_pct = !i_drive_enable ? 8'h00 :
                         (i_demand_pct > i_limit_pct) ? i_limit_pct : i_demand_pct;
endmodule : sdpm_motor_model

// ===== sim/tb_servo_drive_protection_monitor.sv
`timescale 1ns/1ps
`define CHK(a, b) begin #1; n_tests++; if ((a) !== (b)) begin miscompares++; \
  $display("unexpected at %0t: value mismatch", $time); end end
module tb_servo_drive_protection_monitor;
  import sdpm_pkg::*;
  localparam int P = 10;
  logic               i_clock = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic               i_undervolt = 1'b0, i_fault_reset = 1'b0, i_enc_step, i_enc_marker;
  logic               o_drive_enable, o_drive_healthy_relay;
  logic [7:0]         i_addr = 8'h00, demand = 8'h00, gap = 8'h00, per_mark = 8'h04;
  logic [7:0]         i_current_pct, o_current_limit_pct;
  logic [31:0]        i_wdata = 32'h0, o_rdata, r;
  logic [15:0]        i_therm_res = 16'h2000, i_mech_speed = 16'h0000;
  logic signed [31:0] i_pos_err = 32'sh0, i_model_err = 32'sh0;
  logic [19:0]        o_disp_speed;
  logic [3:0]         pp;
  sdpm_fault_t        o_faults;
  sdpm_ind_t          o_ind;
  integer             miscompares = 0, n_tests = 0, seed = 32'hdd546d91, k;

  initial forever #12.5 i_clock = ~i_clock;

  sdpm_monitor #(.CTRL_PERIOD(P), .FREQ_WIN(100)) u_dut (.i_clock, .i_rst_n, .i_addr,
    .i_wdata, .i_wr, .i_rd, .o_rdata, .i_therm_res, .i_current_pct, .i_enc_step,
    .i_enc_dir(1'b0), .i_enc_marker, .i_pos_err, .i_model_err, .i_mech_speed, .i_undervolt,
    .i_fault_reset, .o_drive_enable, .o_drive_healthy_relay, .o_current_limit_pct,
    .o_disp_speed, .o_faults, .o_ind);
  sdpm_motor_model u_motor (.i_clock, .i_drive_enable(o_drive_enable),
    .i_limit_pct(o_current_limit_pct), .i_demand_pct(demand), .i_gap(gap),
    .i_per_mark(per_mark), .o_enc_step(i_enc_step), .o_enc_marker(i_enc_marker),
    .o_current_pct(i_current_pct));

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clock);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    cyc(1);
    i_wr <= 1'b0;
    cyc(1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    i_addr <= a;
    i_rd <= 1'b1;
    cyc(1);
    i_rd <= 1'b0;
    `CHK(o_rdata, e)
    cyc(1);
  endtask : rd
  task automatic clear;
    i_fault_reset <= 1'b1;
    cyc(1);
    i_fault_reset <= 1'b0;
    cyc(1);
  endtask : clear
  task automatic summarize;
    $display("miscompares %0d, n_tests %0d", miscompares, n_tests);
    if (miscompares == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize
  task automatic wait_fault(input int b, input int lim);
    k = 0;
    while (o_faults[b] !== 1'b1 && k < lim)
    begin
      cyc(1);
      #1;
      k++;
    end
    if (o_faults[b] !== 1'b1)
    begin
      miscompares++;
      $display("unexpected at %0t: wait ran out", $time);
      summarize();
    end
  endtask : wait_fault

  initial
  begin
    cyc(5);
    i_rst_n <= 1'b1;
    cyc(1);
    rd(ADDR_CTRL, 32'h0);
    rd(ADDR_THERM_WARN, {16'h0, THERM_WARN_RST});
    rd(ADDR_RATED_CUR, 32'h32);
    rd(8'hfc, 32'h0);
    `CHK(o_current_limit_pct, 8'h64)
    for (int j = 0; j < 8; j++)
    begin
      r = $random(seed);
      pp = 4'($random(seed));
      wr(ADDR_POLE_PAIRS, {28'h0, pp});
      wr(ADDR_FOLLOW_THR, r);
      rd(ADDR_FOLLOW_THR, r);
      i_mech_speed <= r[15:0];
      cyc(2);
      `CHK(o_disp_speed, 20'(r[15:0]) * pp)
    end
    wr(ADDR_STATUS, 32'hffff_ffff);
    rd(ADDR_STATUS, 32'h0);
    wr(ADDR_THERM_WARN, 32'h1000);
    wr(ADDR_THERM_TRIP, 32'h0800);
    i_therm_res <= 16'h0c00;
    cyc(3 * P);
    `CHK({o_ind.therm_warn, o_drive_enable}, 2'b11)
    i_therm_res <= 16'h0800;
    cyc(3 * P);
    `CHK({o_faults, o_drive_healthy_relay}, 6'b000010)
    i_therm_res <= 16'h2000;
    clear();
    `CHK(o_faults, 5'h00)
    wr(ADDR_FOLLOW_THR, 32'd100);
    i_pos_err <= 32'sd100;
    cyc(3 * P);
    `CHK(o_faults.follow, 1'b0)
    i_pos_err <= 32'sd101;
    cyc(3 * P);
    `CHK(o_faults.follow, 1'b1)
    wr(ADDR_CTRL, 32'h2);
    i_pos_err <= 32'sd105;
    i_model_err <= 32'sd5;
    clear();
    cyc(3 * P);
    `CHK(o_faults.follow, 1'b0)
    i_model_err <= 32'sd4;
    cyc(3 * P);
    `CHK(o_faults.follow, 1'b1)
    i_pos_err <= 32'sd0;
    i_model_err <= 32'sd0;
    wr(ADDR_CTRL, 32'ha);
    `CHK(o_faults, 5'h00)
    wr(ADDR_ENC_CPR, 32'd4);
    wr(ADDR_MAX_SPEED, 32'd10000);
    gap <= 8'd8;
    cyc(200);
    `CHK(o_faults.count, 1'b0)
    per_mark <= 8'd5;
    wait_fault(2, 200);
    `CHK(o_drive_enable, 1'b0)
    wr(ADDR_MARK_PITCH, 32'd0);
    clear();
    cyc(200);
    `CHK(o_faults.count, 1'b0)
    wr(ADDR_MAX_SPEED, 32'd1000);
    wait_fault(2, 300);
    wr(ADDR_MAX_SPEED, 32'd10000);
    wr(ADDR_MARK_PITCH, 32'd15);
    clear();
    wait_fault(2, 300);
    gap <= 8'd0;
    cyc(2);
    clear();
    demand <= 8'd100;
    cyc(700 * P);
    `CHK({o_ind, o_faults}, 8'h00)
    cyc(700 * P);
    `CHK({o_ind.oc_clamp, o_current_limit_pct}, 9'h132)
    rd(ADDR_I2T_LEVEL, (32'(RATED_CUR_RST) * 32'(RATED_CUR_RST)) / 32'd50);
    `CHK(o_faults, 5'h00)
    wait_fault(1, 800 * P);
    `CHK(o_drive_healthy_relay, 1'b0)
    i_rst_n <= 1'b0;
    cyc(5);
    i_rst_n <= 1'b1;
    cyc(1);
    wr(ADDR_CTRL, 32'h1);
    cyc(2200 * P);
    `CHK({o_faults, o_drive_enable}, 6'b000001)
    k = 0;
    repeat (130 * P)
    begin
      cyc(1);
      #1;
      if (o_ind.oc_blink === 1'b1)
        k++;
    end
    `CHK((k > 0) && (k < 130 * P), 1'b1)
    i_undervolt <= 1'b1;
    cyc(1);
    i_undervolt <= 1'b0;
    `CHK({o_faults.uv, o_drive_healthy_relay}, 2'b11)
    wr(ADDR_CTRL, 32'hc);
    i_undervolt <= 1'b1;
    cyc(1);
    i_undervolt <= 1'b0;
    `CHK({o_faults.uv, o_drive_healthy_relay}, 2'b10)
    summarize();
  end
endmodule : tb_servo_drive_protection_monitor
